/* File: rtl/uartsr_pkg.sv */
// package: register map, field layout, timing and shared helpers of the serial port
package uartsr_pkg;

  localparam int ADDR_W = 12;
  localparam logic [11:0] OFS_DATA = 12'h000;
  localparam logic [11:0] OFS_STAT = 12'h004;
  localparam logic [11:0] OFS_LINE = 12'h008;
  localparam logic [11:0] OFS_CTRL = 12'h00C;
  localparam logic [11:0] OFS_IDIV = 12'h010;
  localparam logic [11:0] OFS_FDIV = 12'h014;
  localparam logic [11:0] OFS_TRIG = 12'h018;
  localparam logic [11:0] OFS_MASK = 12'h01C;
  localparam logic [11:0] OFS_RAW = 12'h020;
  localparam logic [11:0] OFS_MIS = 12'h024;
  localparam logic [11:0] OFS_ICLR = 12'h028;
  localparam logic [11:0] OFS_DMAC = 12'h02C;
  localparam logic [11:0] OFS_LPDV = 12'h030;

  // control register fields
  localparam int CR_TXE = 0;
  localparam int CR_RXE = 1;
  localparam int CR_DTR = 2;
  localparam int CR_RTS = 3;
  localparam int CR_RTSEN = 4;
  localparam int CR_CTSEN = 5;
  localparam int CR_SIREN = 6;
  localparam int CR_SIRLP = 7;
  localparam int CR_CLKSEL = 8;
  localparam logic [8:0] CR_RST = 9'h003;

  // interrupt cause bits
  localparam int IR_TX = 0;
  localparam int IR_RX = 1;
  localparam int IR_RT = 2;
  localparam int IR_MS = 3;
  localparam int IR_FE = 4;
  localparam int IR_PE = 5;
  localparam int IR_BE = 6;
  localparam int IR_OE = 7;

  // status register fields
  localparam int ST_TXFE = 0;
  localparam int ST_TXFF = 1;
  localparam int ST_RXFE = 2;
  localparam int ST_RXFF = 3;
  localparam int ST_BUSY = 4;
  localparam int ST_MODEM = 5;

  localparam int DMA_RXE = 0;
  localparam int DMA_TXE = 1;
  localparam int TRIG_TX_LSB = 0;
  localparam int TRIG_RX_LSB = 3;
  localparam logic [5:0] TRIG_RST = 6'h12;
  localparam logic [15:0] IDIV_RST = 16'h0000;
  localparam logic [7:0] LPDV_RST = 8'h00;

  localparam int FIFO_DEPTH = 16;
  localparam logic [4:0] DEPTH_ON = 5'h10;
  localparam logic [4:0] DEPTH_OFF = 5'h01;

  // timing
  localparam longint SYS_CLK_HZ = 100_000_000;
  localparam longint REF_CLK_HZ = 48_000_000;
  localparam logic [15:0] REF_STEP = 16'((REF_CLK_HZ << 16) / SYS_CLK_HZ);
  localparam logic [3:0] TICK_LAST = 4'hF;
  localparam logic [3:0] TICK_MID = 4'h7;
  localparam logic [3:0] SIR_PULSE = 4'h3;
  localparam logic [1:0] SIR_LP_PULSE = 2'h3;
  localparam logic [4:0] SIR_STRETCH = 5'h10;
  localparam logic [9:0] RT_TICKS = 10'h200;

  typedef struct packed {
    logic brk;
    logic par_en;
    logic par_even;
    logic par_stick;
    logic stop2;
    logic fifo_en;
    logic [1:0] wlen;
  } uartsr_line_t;

  typedef struct packed {
    logic oe;
    logic be;
    logic pe;
    logic fe;
    logic [7:0] data;
  } uartsr_rxent_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_START = 3'h1,
    S_DATA = 3'h3,
    S_PAR = 3'h2,
    S_STOP = 3'h6
  } uartsr_state_t;

  // trigger level in entries for a 16-deep fifo
  function automatic logic [4:0] trig_level(input logic [2:0] sel);
    case (sel)
      3'h0: trig_level = 5'h02;
      3'h1: trig_level = 5'h04;
      3'h2: trig_level = 5'h08;
      3'h3: trig_level = 5'h0C;
      default: trig_level = 5'h0E;
    endcase
  endfunction : trig_level

  function automatic logic par_bit(input logic [7:0] d, input uartsr_line_t l);
    logic [7:0] m;
    logic x;
    m = d & (8'hFF >> (3'h3 - {1'b0, l.wlen}));
    x = ^m;
    par_bit = l.par_stick ? ~l.par_even : (l.par_even ? x : ~x);
  endfunction : par_bit

endpackage : uartsr_pkg

/* File: rtl/uartsr_top.sv */
// serial port with fifos, fractional baud generator, modem lines and infrared pulse codec
`timescale 1ns/1ns
module uartsr_top (
  input wire logic SYS_CLK_I,
  input wire logic NRST_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic PREADY_O,
  output logic [31:0] PRDATA_O,
  output logic PSLVERR_O,
  input wire logic [15:0] CLK_SYNTH_SETTING_I,
  input wire logic RXD_I,
  input wire logic SIR_IN_I,
  input wire logic CTS_N_I,
  input wire logic DCD_N_I,
  input wire logic DSR_N_I,
  input wire logic RI_N_I,
  output logic TXD_O,
  output logic SIR_OUT_O,
  output logic RTS_N_O,
  output logic DTR_N_O,
  output logic IRQ_O,
  output logic TX_DMA_REQ_O,
  output logic RX_DMA_REQ_O
);

  // configuration registers
  uartsr_pkg::uartsr_line_t line;
  logic [8:0] ctrl;
  logic [15:0] idiv;
  logic [5:0] fdiv;
  logic [5:0] trig;
  logic [7:0] imask;
  logic [7:3] sticky;
  logic [1:0] dmac;
  logic [7:0] lpdv;

  // input synchronisers: rxd, sir, cts, dcd, dsr, ri (pins active low except data)
  logic [5:0] sy1, sy2, sy3, pin;
  wire [5:0] pin_raw = {RI_N_I, DSR_N_I, DCD_N_I, CTS_N_I, SIR_IN_I, RXD_I};
  wire [5:0] pin_diff = sy2 ^ sy3;
  wire [5:0] next_pin = (sy2 & ~pin_diff) | (pin & pin_diff);
  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      sy1 <= 6'h3D;
      sy2 <= 6'h3D;
      sy3 <= 6'h3D;
      pin <= 6'h3D;
    end else begin
      sy1 <= pin_raw;
      sy2 <= sy1;
      sy3 <= sy2;
      pin <= next_pin;
    end
  end
  wire cts_on = ~pin[2];
  wire [3:0] modem_now = ~pin[5:2];
  logic [3:0] modem_prev;

  // reference clock as a phase-accumulator enable; 48 MHz fixed or external step
  logic [15:0] ref_acc;
  logic ref_en;
  wire [15:0] ref_step = ctrl[uartsr_pkg::CR_CLKSEL] ? CLK_SYNTH_SETTING_I : uartsr_pkg::REF_STEP;
  wire [16:0] ref_sum = {1'b0, ref_acc} + {1'b0, ref_step};
  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      ref_acc <= 16'h0000;
      ref_en <= 1'b0;
    end else begin
      ref_acc <= ref_sum[15:0];
      ref_en <= ref_sum[16];
    end
  end

  // 16x oversampling tick; fractional carry stretches a period by one reference cycle
  logic [15:0] bcnt;
  logic [5:0] facc;
  logic tick;
  wire [15:0] idiv_eff = (idiv == 16'h0000) ? 16'h0001 : idiv;
  wire [6:0] fsum = {1'b0, facc} + {1'b0, fdiv};
  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      bcnt <= 16'h0000;
      facc <= 6'h00;
      tick <= 1'b0;
    end else begin
      tick <= ref_en && bcnt == 16'h0000;
      if (ref_en) begin
        if (bcnt == 16'h0000) begin
          facc <= fsum[5:0];
          bcnt <= idiv_eff - 16'h0001 + {15'h0000, fsum[6]};
        end else begin
          bcnt <= bcnt - 16'h0001;
        end
      end
    end
  end

  // apb decode; one wait-free access phase, read data captured in setup
  wire setup = PSEL_I && !PENABLE_I;
  wire done = PSEL_I && PENABLE_I && PREADY_O;
  wire wr = done && PWRITE_I;
  wire rd = done && !PWRITE_I;
  wire mapped = PADDR_I[1:0] == 2'h0 && PADDR_I <= uartsr_pkg::OFS_LPDV;
  wire hit_data = PADDR_I == uartsr_pkg::OFS_DATA;

  // fifos
  logic [7:0] tx_mem [uartsr_pkg::FIFO_DEPTH];
  logic [11:0] rx_mem [uartsr_pkg::FIFO_DEPTH];
  logic [3:0] tx_wp, tx_rp, rx_wp, rx_rp;
  logic [4:0] tx_cnt, rx_cnt;
  wire [4:0] depth = line.fifo_en ? uartsr_pkg::DEPTH_ON : uartsr_pkg::DEPTH_OFF;
  wire [4:0] tx_lvl = uartsr_pkg::trig_level(trig[uartsr_pkg::TRIG_TX_LSB +: 3]);
  wire [4:0] rx_lvl_raw = uartsr_pkg::trig_level(trig[uartsr_pkg::TRIG_RX_LSB +: 3]);
  wire [4:0] rx_lvl = line.fifo_en ? rx_lvl_raw : 5'h01;
  wire tx_push = wr && hit_data && tx_cnt < depth;
  wire rx_pop = rd && hit_data && rx_cnt != 5'h00;
  logic tx_pop, rx_push;
  uartsr_pkg::uartsr_rxent_t rx_ent;

  always_ff @(posedge SYS_CLK_I) begin
    if (tx_push) begin
      tx_mem[tx_wp] <= PWDATA_I[7:0];
    end
    if (rx_push) begin
      rx_mem[rx_wp] <= rx_ent;
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      tx_wp <= 4'h0;
      tx_rp <= 4'h0;
      tx_cnt <= 5'h00;
      rx_wp <= 4'h0;
      rx_rp <= 4'h0;
      rx_cnt <= 5'h00;
    end else begin
      tx_wp <= tx_wp + {3'h0, tx_push};
      tx_rp <= tx_rp + {3'h0, tx_pop};
      tx_cnt <= tx_cnt + {4'h0, tx_push} - {4'h0, tx_pop};
      rx_wp <= rx_wp + {3'h0, rx_push};
      rx_rp <= rx_rp + {3'h0, rx_pop};
      rx_cnt <= rx_cnt + {4'h0, rx_push} - {4'h0, rx_pop};
    end
  end

  // transmitter
  uartsr_pkg::uartsr_state_t tx_st;
  logic [3:0] tx_tk;
  logic [2:0] tx_bit;
  logic [7:0] tx_sh;
  logic tx_par, tx_line;
  wire [2:0] nbits_last = {1'b0, line.wlen} + 3'h4;
  wire tx_bit_end = tick && tx_tk == uartsr_pkg::TICK_LAST;
  wire tx_may_start = ctrl[uartsr_pkg::CR_TXE] && tx_cnt != 5'h00
    && (!ctrl[uartsr_pkg::CR_CTSEN] || cts_on);
  assign tx_pop = tx_st == uartsr_pkg::S_IDLE && tick && tx_may_start;

  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      tx_st <= uartsr_pkg::S_IDLE;
      tx_tk <= 4'h0;
      tx_bit <= 3'h0;
      tx_sh <= 8'h00;
      tx_par <= 1'b0;
      tx_line <= 1'b1;
    end else begin
      if (tick && tx_st != uartsr_pkg::S_IDLE) begin
        tx_tk <= tx_tk + 4'h1;
      end
      case (tx_st)
        uartsr_pkg::S_IDLE: begin
          if (tx_pop) begin
            tx_sh <= tx_mem[tx_rp];
            tx_par <= uartsr_pkg::par_bit(tx_mem[tx_rp], line);
            tx_tk <= 4'h0;
            tx_line <= 1'b0;
            tx_st <= uartsr_pkg::S_START;
          end
        end
        uartsr_pkg::S_START: begin
          if (tx_bit_end) begin
            tx_line <= tx_sh[0];
            tx_sh <= {1'b0, tx_sh[7:1]};
            tx_bit <= 3'h0;
            tx_st <= uartsr_pkg::S_DATA;
          end
        end
        uartsr_pkg::S_DATA: begin
          if (tx_bit_end) begin
            tx_bit <= tx_bit + 3'h1;
            if (tx_bit != nbits_last) begin
              tx_line <= tx_sh[0];
              tx_sh <= {1'b0, tx_sh[7:1]};
            end else if (line.par_en) begin
              tx_line <= tx_par;
              tx_st <= uartsr_pkg::S_PAR;
            end else begin
              tx_line <= 1'b1;
              tx_bit <= 3'h0;
              tx_st <= uartsr_pkg::S_STOP;
            end
          end
        end
        uartsr_pkg::S_PAR: begin
          if (tx_bit_end) begin
            tx_line <= 1'b1;
            tx_bit <= 3'h0;
            tx_st <= uartsr_pkg::S_STOP;
          end
        end
        uartsr_pkg::S_STOP: begin
          if (tx_bit_end) begin
            tx_bit <= 3'h1;
            if (tx_bit != 3'h0 || !line.stop2) begin
              tx_st <= uartsr_pkg::S_IDLE;
            end
          end
        end
        default: tx_st <= uartsr_pkg::S_IDLE;
      endcase
    end
  end
  wire tx_active = tx_st != uartsr_pkg::S_IDLE;

  // infrared encoder; low-power pulse is three ticks of a divided reference
  logic [7:0] lp_cnt;
  logic [1:0] lp_run;
  wire lp_tick = ref_en && lp_cnt == 8'h00;
  wire zero_start = tick && tx_tk == 4'h0 && tx_active && !tx_line;
  wire sir_en = ctrl[uartsr_pkg::CR_SIREN];
  wire sir_lp = ctrl[uartsr_pkg::CR_SIRLP];
  wire pulse_norm = tx_active && !tx_line && tx_tk < uartsr_pkg::SIR_PULSE;
  wire sir_tx_pulse = sir_en && (sir_lp ? lp_run != 2'h0 : pulse_norm);
  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      lp_cnt <= 8'h00;
      lp_run <= 2'h0;
    end else begin
      if (ref_en) begin
        lp_cnt <= (lp_cnt == 8'h00) ? lpdv - 8'h01 : lp_cnt - 8'h01;
      end
      if (zero_start) begin
        lp_run <= uartsr_pkg::SIR_LP_PULSE;
      end else if (lp_tick && lp_run != 2'h0) begin
        lp_run <= lp_run - 2'h1;
      end
    end
  end

  // infrared decoder; own transmission blanks the receiver (half duplex)
  logic [4:0] sir_hold;
  wire sir_seen = pin[1] && !tx_active;
  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      sir_hold <= 5'h00;
    end else if (sir_seen) begin
      sir_hold <= uartsr_pkg::SIR_STRETCH;
    end else if (tick && sir_hold != 5'h00) begin
      sir_hold <= sir_hold - 5'h01;
    end
  end
  wire rx_line = sir_en ? sir_hold == 5'h00 : pin[0];

  // receiver
  uartsr_pkg::uartsr_state_t rx_st;
  logic [3:0] rx_tk;
  logic [2:0] rx_bit;
  logic [7:0] rx_sh;
  logic rx_pbit, rx_armed, oe_pend;
  wire rx_sample = tick && rx_tk == uartsr_pkg::TICK_LAST;
  wire [7:0] rx_data = rx_sh >> (3'h3 - {1'b0, line.wlen});
  wire rx_full = rx_cnt >= depth;
  assign rx_push = rx_st == uartsr_pkg::S_STOP && rx_sample && !rx_full;
  wire rx_drop = rx_st == uartsr_pkg::S_STOP && rx_sample && rx_full;
  wire ev_brk = !rx_line && rx_data == 8'h00 && !rx_pbit;
  wire ev_pe = line.par_en && rx_pbit != uartsr_pkg::par_bit(rx_data, line);
  assign rx_ent = '{oe: oe_pend, be: ev_brk, pe: ev_pe, fe: !rx_line, data: rx_data};

  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rx_st <= uartsr_pkg::S_IDLE;
      rx_tk <= 4'h0;
      rx_bit <= 3'h0;
      rx_sh <= 8'h00;
      rx_pbit <= 1'b0;
      rx_armed <= 1'b0;
      oe_pend <= 1'b0;
    end else begin
      if (tick && rx_st != uartsr_pkg::S_IDLE) begin
        rx_tk <= rx_tk + 4'h1;
      end
      if (rx_drop) begin
        oe_pend <= 1'b1;
      end else if (rx_push) begin
        oe_pend <= 1'b0;
      end
      case (rx_st)
        uartsr_pkg::S_IDLE: begin
          rx_armed <= rx_armed || rx_line;
          if (tick && rx_armed && !rx_line && ctrl[uartsr_pkg::CR_RXE]) begin
            rx_tk <= 4'h0;
            rx_armed <= 1'b0;
            rx_st <= uartsr_pkg::S_START;
          end
        end
        uartsr_pkg::S_START: begin
          if (tick && rx_tk == uartsr_pkg::TICK_MID) begin
            rx_tk <= 4'h0;
            rx_bit <= 3'h0;
            rx_pbit <= 1'b0;
            rx_st <= rx_line ? uartsr_pkg::S_IDLE : uartsr_pkg::S_DATA;
          end
        end
        uartsr_pkg::S_DATA: begin
          if (rx_sample) begin
            rx_sh <= {rx_line, rx_sh[7:1]};
            rx_bit <= rx_bit + 3'h1;
            if (rx_bit == nbits_last) begin
              rx_st <= line.par_en ? uartsr_pkg::S_PAR : uartsr_pkg::S_STOP;
            end
          end
        end
        uartsr_pkg::S_PAR: begin
          if (rx_sample) begin
            rx_pbit <= rx_line;
            rx_st <= uartsr_pkg::S_STOP;
          end
        end
        uartsr_pkg::S_STOP: begin
          if (rx_sample) begin
            rx_st <= uartsr_pkg::S_IDLE;
          end
        end
        default: rx_st <= uartsr_pkg::S_IDLE;
      endcase
    end
  end

  // receive timeout: idle oversampling ticks counted while data waits
  logic [9:0] rt_cnt;
  wire rt_hit = rt_cnt >= uartsr_pkg::RT_TICKS;
  wire rt_clr = rx_push || rx_pop || rx_cnt == 5'h00
    || (wr && PADDR_I == uartsr_pkg::OFS_ICLR && PWDATA_I[uartsr_pkg::IR_RT]);
  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rt_cnt <= 10'h000;
    end else if (rt_clr) begin
      rt_cnt <= 10'h000;
    end else if (tick && !rt_hit && rx_st == uartsr_pkg::S_IDLE) begin
      rt_cnt <= rt_cnt + 10'h001;
    end
  end

  // interrupt causes; for causes 7:3 a hardware set wins over a clear in the same cycle, for the timeout the clear wins
  wire tx_trig = line.fifo_en ? tx_cnt <= tx_lvl : tx_cnt == 5'h00;
  wire rx_trig = rx_cnt >= rx_lvl;
  wire [7:3] ev_set = {rx_drop, rx_push && ev_brk, rx_push && ev_pe,
    rx_push && !rx_line, modem_now != modem_prev};
  wire [7:3] ev_clr = (wr && PADDR_I == uartsr_pkg::OFS_ICLR) ? PWDATA_I[7:3] : 5'h00;
  wire [7:0] raw = {sticky, rt_hit, rx_trig, tx_trig};
  wire [7:0] masked = raw & imask;

  // register writes
  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      line <= '0;
      ctrl <= uartsr_pkg::CR_RST;
      idiv <= uartsr_pkg::IDIV_RST;
      fdiv <= 6'h00;
      trig <= uartsr_pkg::TRIG_RST;
      imask <= 8'h00;
      dmac <= 2'h0;
      lpdv <= uartsr_pkg::LPDV_RST;
      sticky <= 5'h00;
      modem_prev <= 4'h0;
    end else begin
      modem_prev <= modem_now;
      sticky <= (sticky & ~ev_clr) | ev_set;
      if (wr) begin
        case (PADDR_I)
          uartsr_pkg::OFS_LINE: line <= PWDATA_I[7:0];
          uartsr_pkg::OFS_CTRL: ctrl <= PWDATA_I[8:0];
          uartsr_pkg::OFS_IDIV: idiv <= PWDATA_I[15:0];
          uartsr_pkg::OFS_FDIV: fdiv <= PWDATA_I[5:0];
          uartsr_pkg::OFS_TRIG: trig <= PWDATA_I[5:0];
          uartsr_pkg::OFS_MASK: imask <= PWDATA_I[7:0];
          uartsr_pkg::OFS_DMAC: dmac <= PWDATA_I[1:0];
          uartsr_pkg::OFS_LPDV: lpdv <= PWDATA_I[7:0];
          default: ;
        endcase
      end
    end
  end

  // read mux
  wire [31:0] rd_data_q = (rx_cnt != 5'h00) ? {20'h00000, rx_mem[rx_rp]} : 32'h00000000;
  wire [31:0] rd_stat = {23'h000000, modem_now, tx_active || tx_cnt != 5'h00,
    rx_full, rx_cnt == 5'h00, tx_cnt >= depth, tx_cnt == 5'h00};
  logic [31:0] rd_mux;
  always_comb begin
    case (PADDR_I)
      uartsr_pkg::OFS_DATA: rd_mux = rd_data_q;
      uartsr_pkg::OFS_STAT: rd_mux = rd_stat;
      uartsr_pkg::OFS_LINE: rd_mux = {24'h000000, line};
      uartsr_pkg::OFS_CTRL: rd_mux = {23'h000000, ctrl};
      uartsr_pkg::OFS_IDIV: rd_mux = {16'h0000, idiv};
      uartsr_pkg::OFS_FDIV: rd_mux = {26'h0000000, fdiv};
      uartsr_pkg::OFS_TRIG: rd_mux = {26'h0000000, trig};
      uartsr_pkg::OFS_MASK: rd_mux = {24'h000000, imask};
      uartsr_pkg::OFS_RAW: rd_mux = {24'h000000, raw};
      uartsr_pkg::OFS_MIS: rd_mux = {24'h000000, masked};
      uartsr_pkg::OFS_DMAC: rd_mux = {30'h00000000, dmac};
      uartsr_pkg::OFS_LPDV: rd_mux = {24'h000000, lpdv};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // registered outputs
  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      PREADY_O <= 1'b0;
      PRDATA_O <= 32'h00000000;
      PSLVERR_O <= 1'b0;
      TXD_O <= 1'b1;
      SIR_OUT_O <= 1'b0;
      RTS_N_O <= 1'b1;
      DTR_N_O <= 1'b1;
      IRQ_O <= 1'b0;
      TX_DMA_REQ_O <= 1'b0;
      RX_DMA_REQ_O <= 1'b0;
    end else begin
      PREADY_O <= setup;
      if (setup) begin
        PRDATA_O <= PWRITE_I ? 32'h00000000 : rd_mux;
        PSLVERR_O <= !mapped;
      end
      TXD_O <= !line.brk && (sir_en || tx_line);
      SIR_OUT_O <= sir_tx_pulse;
      RTS_N_O <= !(ctrl[uartsr_pkg::CR_RTS]
        && (!ctrl[uartsr_pkg::CR_RTSEN] || rx_cnt < rx_lvl));
      DTR_N_O <= !ctrl[uartsr_pkg::CR_DTR];
      IRQ_O <= |masked;
      TX_DMA_REQ_O <= dmac[uartsr_pkg::DMA_TXE] && tx_trig;
      RX_DMA_REQ_O <= dmac[uartsr_pkg::DMA_RXE] && (rx_trig || rt_hit);
    end
  end

endmodule : uartsr_top

/* File: bench/uartsr_checker.sv */
// checker: bus answer timing, modem output lines and serial bit widths
`timescale 1ns/1ns
module uartsr_checker (
  input wire logic SYS_CLK_I,
  input wire logic NRST_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic PREADY_O,
  input wire logic PSLVERR_O,
  input wire logic TXD_O,
  input wire logic RTS_N_O,
  input wire logic DTR_N_O
);
  logic [5:0] lo_cnt;
  wire acc = PSEL_I && PENABLE_I && PREADY_O;
  wire bad = PADDR_I > uartsr_pkg::OFS_LPDV || PADDR_I[1:0] != 2'h0;
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (!NRST_I);
  // saturating length of the current low run on the serial output
  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      lo_cnt <= 6'h00;
    end else begin
      lo_cnt <= TXD_O ? 6'h00 : lo_cnt + {5'h00, lo_cnt != 6'h3F};
    end
  end
  sequence ctrl_wr;
    acc && PWRITE_I && PADDR_I == uartsr_pkg::OFS_CTRL;
  endsequence
  chk_setup_ready: assert property (PSEL_I && !PENABLE_I |=> PREADY_O)
    else $error("no answer after setup");
  chk_ready_once: assert property (PREADY_O |=> !PREADY_O)
    else $error("ready held too long");
  chk_unmapped_err: assert property (acc && bad |-> PSLVERR_O)
    else $error("unmapped access not flagged");
  chk_mapped_ok: assert property (acc && !bad |-> !PSLVERR_O)
    else $error("mapped access flagged");
  chk_err_hold: assert property (!(PSEL_I && !PENABLE_I) |=> $stable(PSLVERR_O))
    else $error("error flag moved outside setup");
  chk_dtr_follow: assert property (ctrl_wr |-> ##2
    DTR_N_O == !$past(PWDATA_I[uartsr_pkg::CR_DTR], 2)) else $error("dtr mismatch");
  chk_rts_follow: assert property (ctrl_wr and !PWDATA_I[uartsr_pkg::CR_RTSEN] |-> ##2
    RTS_N_O == !$past(PWDATA_I[uartsr_pkg::CR_RTS], 2)) else $error("rts mismatch");
  // a bit lasts 16 ticks and a tick is never shorter than one clock
  chk_low_min: assert property ($rose(TXD_O) |-> lo_cnt >= 6'h0F)
    else $error("serial low run too short");
endmodule : uartsr_checker
bind uartsr_top uartsr_checker u_chk (.SYS_CLK_I(SYS_CLK_I), .NRST_I(NRST_I),
  .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
  .PWDATA_I(PWDATA_I), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .TXD_O(TXD_O),
  .RTS_N_O(RTS_N_O), .DTR_N_O(DTR_N_O));

/* File: bench/uartsr_line_model.sv */
// remote serial device: 8N1 sender and receiver on the plain lines
`timescale 1ns/1ns
module uartsr_line_model (
  input wire logic clk_i,
  input wire logic txd_i,
  output logic rxd_o,
  output logic cts_n_o
);
  // 33 clocks is one bit at divisor 1; drift over a frame stays well inside half a bit
  localparam int BIT = 33;
  logic [7:0] got_q[$];
  initial begin
    rxd_o = 1'b1;
    cts_n_o = 1'b0;
  end
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd_o <= f[i];
      repeat (BIT) @(posedge clk_i);
    end
  endtask : send
  always begin : catcher
    logic [7:0] b;
    @(negedge txd_i);
    repeat (BIT / 2) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge clk_i);
      b[i] = txd_i;
    end
    repeat (BIT) @(posedge clk_i);
    got_q.push_back(b);
  end
endmodule : uartsr_line_model

/* File: bench/tb_uart_with_sir_sir_pulse_codec.sv */
// testbench: registers, serial traffic, modem lines, flow control and break
`timescale 1ns/1ns
module tb_uart_with_sir_sir_pulse_codec;
  logic clk, nrst, psel, pen, pwr, rxd, cts_n, dsr_n, dcd_n, ri_n;
  logic pready, pslverr, txd, rts_n, dtr_n, irq, txdma, rxdma, sirout;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int fails, cmp_count, hi;
  uartsr_top dut (.SYS_CLK_I(clk), .NRST_I(nrst), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PREADY_O(pready),
    .PRDATA_O(prdata), .PSLVERR_O(pslverr), .CLK_SYNTH_SETTING_I(16'h0000),
    .RXD_I(rxd), .SIR_IN_I(1'b0),
    .CTS_N_I(cts_n), .DCD_N_I(dcd_n), .DSR_N_I(dsr_n),
    .RI_N_I(ri_n), .TXD_O(txd), .SIR_OUT_O(sirout), .RTS_N_O(rts_n), .DTR_N_O(dtr_n),
    .IRQ_O(irq), .TX_DMA_REQ_O(txdma), .RX_DMA_REQ_O(rxdma));
  uartsr_line_model line (.clk_i(clk), .txd_i(txd), .rxd_o(rxd), .cts_n_o(cts_n));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rdc
  task automatic wq(input int n);
    for (int i = 0; i < 3000 && line.got_q.size() < n; i++) @(posedge clk);
  endtask : wq
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (30000) @(posedge clk);
    fails++;
    report_and_stop();
  end
  initial begin
    nrst = 1'b0;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    dsr_n = 1'b1;
    dcd_n = 1'b1;
    ri_n = 1'b1;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rdc(uartsr_pkg::OFS_CTRL, {23'h0, uartsr_pkg::CR_RST});
    rdc(uartsr_pkg::OFS_TRIG, {26'h0, uartsr_pkg::TRIG_RST});
    rdc(12'h034, 32'h0);
    chk({31'h0, pslverr}, 32'h1);
    apb(1'b1, uartsr_pkg::OFS_IDIV, 32'h1);
    apb(1'b1, uartsr_pkg::OFS_LINE, 32'h07);
    apb(1'b1, uartsr_pkg::OFS_DATA, 32'h55);
    apb(1'b1, uartsr_pkg::OFS_DATA, 32'hA3);
    wq(2);
    chk({24'h0, line.got_q[0]}, 32'h55);
    chk({24'h0, line.got_q[1]}, 32'hA3);
    line.send(8'h3C);
    line.send(8'hC3);
    rdc(uartsr_pkg::OFS_DATA, 32'h03C);
    rdc(uartsr_pkg::OFS_DATA, 32'h0C3);
    rdc(uartsr_pkg::OFS_DATA, 32'h0);
    // fifo off: the second character finds the holding place full
    apb(1'b1, uartsr_pkg::OFS_LINE, 32'h03);
    line.send(8'h11);
    line.send(8'h22);
    rdc(uartsr_pkg::OFS_DATA, 32'h011);
    rdc(uartsr_pkg::OFS_DATA, 32'h0);
    apb(1'b1, uartsr_pkg::OFS_LINE, 32'h07);
    apb(1'b1, uartsr_pkg::OFS_CTRL, 32'h00F);
    @(posedge clk);
    chk({30'h0, dtr_n, rts_n}, 32'h0);
    apb(1'b1, uartsr_pkg::OFS_ICLR, 32'h08);
    apb(1'b1, uartsr_pkg::OFS_MASK, 32'h08);
    @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    dsr_n <= 1'b0;
    dcd_n <= 1'b0;
    repeat (8) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    apb(1'b0, uartsr_pkg::OFS_STAT, 32'h0);
    chk({28'h0, rd[8:5]}, 32'h7);
    apb(1'b1, uartsr_pkg::OFS_ICLR, 32'h08);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, uartsr_pkg::OFS_MASK, 32'h0);
    dsr_n <= 1'b1;
    dcd_n <= 1'b1;
    repeat (8) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    apb(1'b0, uartsr_pkg::OFS_RAW, 32'h0);
    chk({30'h0, rd[7], rd[3]}, 32'h3);
    // cts must be through the synchroniser before the character is queued
    line.cts_n_o <= 1'b1;
    apb(1'b1, uartsr_pkg::OFS_CTRL, 32'h023);
    apb(1'b1, uartsr_pkg::OFS_DATA, 32'h5A);
    repeat (400) @(posedge clk);
    chk(32'(line.got_q.size()), 32'h2);
    line.cts_n_o <= 1'b0;
    wq(3);
    chk({24'h0, line.got_q[2]}, 32'h5A);
    apb(1'b1, uartsr_pkg::OFS_DMAC, 32'h3);
    repeat (3) @(posedge clk);
    chk({30'h0, txdma, rxdma}, 32'h2);
    apb(1'b1, uartsr_pkg::OFS_CTRL, 32'h041);
    apb(1'b1, uartsr_pkg::OFS_DATA, 32'h00);
    // width of the first pulse: three ticks of about two clocks each
    hi = 0;
    for (int i = 0; i < 100 && (hi == 0 || sirout === 1'b1); i++) begin
      @(posedge clk);
      if (sirout === 1'b1) hi++;
    end
    chk({31'h0, hi inside {6, 7}}, 32'h1);
    chk({31'h0, txd}, 32'h1);
    apb(1'b1, uartsr_pkg::OFS_LINE, 32'h87);
    repeat (3) @(posedge clk);
    chk({31'h0, txd}, 32'h0);
    report_and_stop();
  end
endmodule : tb_uart_with_sir_sir_pulse_codec
